// file: rtl/cfg_regs.sv
`include "sar_ctrl_consts.svh"

module cfg_regs (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [8:0] rd_addr,
  output logic      [7:0] rd_data,
  input  wire logic       wr_en,
  input  wire logic [8:0] wr_addr,
  input  wire logic [7:0] wr_data,
  output logic            launch_sel
);

  sar_ctrl_pkg::cfg_s st;
  sar_ctrl_pkg::cfg_s next_st;

  always_comb begin
    next_st = st;
    // Unmapped addresses read as zero and ignore writes
    next_st.rd_data = 8'h00;
    for (int i = 0; i < `NUM_CFG_REGS; i++) begin
      if (rd_addr == 9'(i)) begin
        next_st.rd_data = st.regs[i];
      end
      if (wr_en && wr_addr == 9'(i)) begin
        next_st.regs[i] = wr_data;
      end
    end
    if (srst) begin
      next_st.rd_data = 8'h00;
      for (int i = 0; i < `NUM_CFG_REGS; i++) begin
        next_st.regs[i] = `CFG_RESET_VAL;
      end
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign rd_data    = st.rd_data;
  assign launch_sel = st.regs[`CFG_LAUNCH_ADDR][`CFG_LAUNCH_BIT];

endmodule : cfg_regs

// file: rtl/sar_ctrl.sv
// Function
// RULE1: Results are 18-bit two's complement, saturating at 20000 and 1FFFF hex.
// RULE2: Only reset, acquire and convert states exist, steered by start and reset pins.
// RULE3: Reset pin acts without the core clock; host holds it low long enough. Here the pin passes two core-clock flip-flops first.
// RULE4: In reset, configuration returns to defaults, ready low, serial output released.
// RULE5: Host releases reset with start low; after exit delay, acquire and ready high.
// RULE6: Host keeps reset high to stay in acquire or convert.
// RULE7: Active status low while converting; ready follows it while chip select is high. Here ready also waits out command fetch and apply.
// RULE8: Acquire is entered after reset and at the end of every conversion.
// RULE9: Reset falling while acquiring enters reset at once.
// RULE10: Start rising while acquiring begins a conversion timed by the internal clock.
// RULE11: Start transitions are ignored until the running conversion completes.
// RULE12: Host spaces conversion starts by conversion time plus acquisition time.
// RULE13: Host waits for ready rising or maximum conversion time before next operation.
// RULE14: Nine configuration registers, reached only by serial commands.
// RULE15: Command word: opcode bits 21-17, address 16-8, data or mask 7-0.
// RULE16: Opcode 10000 clears masked bits of the addressed register.
// RULE17: Opcode 10011 sets masked bits of the addressed register.
// RULE18: Opcode 10010 writes the data field into the addressed register.
// RULE19: Opcode 10001 reads the addressed register; host sends zero low byte.
// RULE20: All-zero, all-one and reserved opcodes do nothing.
// RULE21: Serial input is captured on the serial clock only.
// RULE22: Output shifting uses serial clock or internal clock, chosen by configuration.
// RULE23: At frame end decode last 22 bits only if 22 or more clocks arrived.
// RULE24: After a read, next frame carries register in bits 21-14, zeros below.
// RULE25: Result is held from conversion end until the next conversion ends.
`include "sar_ctrl_consts.svh"

module sar_ctrl (
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  input  wire logic        RST_N,
  input  wire logic        CONVERSION_START,
  input  wire logic        CS_N,
  input  wire logic        SCLK,
  input  wire logic        SDI,
  input  wire logic [19:0] ANALOG_CODE,
  output logic             SDO,
  output logic             SDO_OE,
  output logic             READY_INDICATOR,
  output logic      [17:0] RESULT
);

  localparam int CONV_CYC = `CONV_CYCLES;
  localparam int EXIT_CYC = `RST_EXIT_CYCLES;

  sar_ctrl_pkg::core_s st;
  sar_ctrl_pkg::core_s next_st;
  sar_ctrl_pkg::link_s link;
  sar_ctrl_pkg::link_s next_link;

  logic [7:0] mem_rd;
  logic       launch_sel;
  logic       cfg_srst;
  logic       launch;
  logic [4:0] opcode;
  logic [7:0] mask;

  function automatic logic [17:0] sat_code(input logic signed [19:0] code);
    logic [17:0] r;
    r = code[17:0];
    if (code < `CODE_MIN_IN) begin
      r = `CODE_NEG_FS;
    end else if (code > `CODE_MAX_IN) begin
      r = `CODE_POS_FS;
    end
    return r;
  endfunction : sat_code

  assign opcode   = st.cmd[`OPC_MSB:`OPC_LSB];
  assign mask     = st.cmd[`DATA_MSB:0];
  assign cfg_srst = SRST || st.state == sar_ctrl_pkg::ST_RESET; // RULE4

  cfg_regs u_cfg ( // RULE14
    .clk        (CORE_CLK),
    .srst       (cfg_srst),
    .rd_addr    (st.cmd[`ADDR_MSB:`ADDR_LSB]),
    .rd_data    (mem_rd),
    .wr_en      (st.wr_en),
    .wr_addr    (st.wr_addr),
    .wr_data    (st.wr_data),
    .launch_sel (launch_sel)
  );

  // Link side: only the serial clock captures input bits
  always_comb begin
    next_link     = link;
    next_link.input_shift_register = {link.input_shift_register[20:0], SDI}; // RULE21
    if (link.cnt < `CMD_MIN_CLOCKS) begin
      next_link.cnt = link.cnt + 5'h01;
    end
  end

  // Cleared from the core while chip select is high; the serial clock
  // stands still then, so the frame count restarts at each frame.
  always_ff @(posedge SCLK or posedge st.link_clr) begin
    if (st.link_clr) begin
      link <= '0;
    end else begin
      link <= next_link;
    end
  end

  always_comb begin
    next_st = st;
    launch  = 1'b0;
    // Reset, start, chip select and serial clock pins pass two flip-flops first
    next_st.rst_s1  = RST_N; // RULE3
    next_st.rst_s2  = st.rst_s1;
    next_st.cnv_s1  = CONVERSION_START;
    next_st.cnv_s2  = st.cnv_s1;
    next_st.cnv_d   = st.cnv_s2;
    next_st.cs_s1   = CS_N;
    next_st.cs_s2   = st.cs_s1;
    next_st.cs_d    = st.cs_s2;
    next_st.sclk_s1 = SCLK;
    next_st.sclk_s2 = st.sclk_s1;
    next_st.sclk_d  = st.sclk_s2;
    next_st.wr_en   = 1'b0;

    unique case (st.state) // RULE2
      sar_ctrl_pkg::ST_RESET: begin
        next_st.active = 1'b1;
        if (st.timer <= 16'h0001) begin
          next_st.state = sar_ctrl_pkg::ST_ACQUIRE; // RULE5 RULE8
        end else begin
          next_st.timer = st.timer - 16'h0001;
        end
      end
      sar_ctrl_pkg::ST_ACQUIRE: begin
        if (st.cnv_s2 && !st.cnv_d) begin
          next_st.state  = sar_ctrl_pkg::ST_CONVERT; // RULE10
          next_st.timer  = 16'(`CONV_CYCLES);
          next_st.active = 1'b0; // RULE7
        end
      end
      sar_ctrl_pkg::ST_CONVERT: begin
        // Start edges are not looked at here
        if (st.timer <= 16'h0001) begin // RULE11
          next_st.state  = sar_ctrl_pkg::ST_ACQUIRE; // RULE8
          next_st.active = 1'b1; // RULE7
          next_st.result = sat_code(ANALOG_CODE); // RULE1 RULE25
        end else begin
          next_st.timer = st.timer - 16'h0001;
        end
      end
      default: begin
        next_st.state = sar_ctrl_pkg::ST_RESET;
      end
    endcase

    // Reset pin low wins over every state, a conversion is abandoned
    if (!st.rst_s2) begin
      next_st.state  = sar_ctrl_pkg::ST_RESET; // RULE9 RULE3
      next_st.timer  = 16'(`RST_EXIT_CYCLES);
      next_st.active = 1'b1;
    end

    // Frame start loads the output word, frame body shifts it out
    if (!st.cs_s2 && st.cs_d) begin
      if (st.rd_pending) begin
        next_st.output_shift_register = {st.rd_data, 14'h0000}; // RULE24
      end else begin
        next_st.output_shift_register = {st.result, 4'h0};
      end
      next_st.rd_pending = 1'b0;
      next_st.div        = 8'h00;
    end else if (!st.cs_s2) begin
      if (launch_sel) begin
        launch = st.div == `INT_LAUNCH_DIV - 8'h01; // RULE22
        next_st.div = launch ? 8'h00 : st.div + 8'h01;
      end else begin
        launch = !st.sclk_s2 && st.sclk_d; // RULE22
      end
      if (launch) begin
        next_st.output_shift_register = {st.output_shift_register[20:0], 1'b0};
      end
    end

    // Link words are stable here: the serial clock is idle after chip select rises
    if (st.cs_s2 && !st.cs_d && st.phase == sar_ctrl_pkg::CMD_IDLE) begin
      if (link.cnt >= `CMD_MIN_CLOCKS) begin // RULE23
        next_st.cmd   = link.input_shift_register;
        next_st.phase = sar_ctrl_pkg::CMD_FETCH;
      end
    end

    unique case (st.phase)
      sar_ctrl_pkg::CMD_IDLE: begin
      end
      sar_ctrl_pkg::CMD_FETCH: begin
        next_st.phase = sar_ctrl_pkg::CMD_APPLY;
      end
      sar_ctrl_pkg::CMD_APPLY: begin
        next_st.phase   = sar_ctrl_pkg::CMD_IDLE;
        next_st.wr_addr = st.cmd[`ADDR_MSB:`ADDR_LSB]; // RULE15
        if (opcode == `OPC_CLR) begin
          next_st.wr_en   = 1'b1;
          next_st.wr_data = mem_rd & ~mask; // RULE16
        end else if (opcode == `OPC_SET) begin
          next_st.wr_en   = 1'b1;
          next_st.wr_data = mem_rd | mask; // RULE17
        end else if (opcode == `OPC_WR) begin
          next_st.wr_en   = 1'b1;
          next_st.wr_data = mask; // RULE18
        end else if (opcode == `OPC_RD) begin
          next_st.rd_pending = 1'b1; // RULE19
          next_st.rd_data    = mem_rd;
        end
        // Anything else, including all zeros and all ones, does nothing
        // RULE20
      end
      default: begin
        next_st.phase = sar_ctrl_pkg::CMD_IDLE;
      end
    endcase

    if (st.state == sar_ctrl_pkg::ST_RESET) begin
      next_st.phase      = sar_ctrl_pkg::CMD_IDLE;
      next_st.rd_pending = 1'b0;
      next_st.wr_en      = 1'b0;
    end

    // Clear follows the delayed chip select, so the frame-end decode still sees the count
    next_st.link_clr = next_st.cs_d || next_st.state == sar_ctrl_pkg::ST_RESET;
    next_st.sdo_oe   = !next_st.cs_s2 && next_st.state != sar_ctrl_pkg::ST_RESET; // RULE4
    // Ready tracks the status only outside frames and outside command work;
    // waiting for the delayed chip select stops a one-cycle pulse before decode
    next_st.ready    = next_st.active && next_st.cs_s2 && next_st.state != sar_ctrl_pkg::ST_RESET
                       && next_st.cs_d && next_st.phase == sar_ctrl_pkg::CMD_IDLE && !next_st.wr_en; // RULE7 RULE4

    if (SRST) begin
      next_st          = '0;
      next_st.state    = sar_ctrl_pkg::ST_RESET;
      next_st.phase    = sar_ctrl_pkg::CMD_IDLE;
      next_st.cs_s1    = 1'b1;
      next_st.cs_s2    = 1'b1;
      next_st.cs_d     = 1'b1;
      next_st.link_clr = 1'b1;
      next_st.active   = 1'b1;
      next_st.timer    = 16'(`RST_EXIT_CYCLES);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    st <= next_st;
  end

  assign SDO             = st.output_shift_register[21];
  assign SDO_OE          = st.sdo_oe;
  assign READY_INDICATOR = st.ready;
  assign RESULT          = st.result;

  a_reset_quiet: assert property ( // RULE4
    @(posedge CORE_CLK) disable iff (SRST)
    st.state == sar_ctrl_pkg::ST_RESET |-> !READY_INDICATOR && !SDO_OE)
    else $error("ready or serial output active in reset");

  a_reset_enter: assert property ( // RULE9
    @(posedge CORE_CLK) disable iff (SRST)
    !st.rst_s2 |=> st.state == sar_ctrl_pkg::ST_RESET && st.timer == 16'(`RST_EXIT_CYCLES))
    else $error("reset pin low did not enter reset");

  a_exit_delay: assert property ( // RULE5
    @(posedge CORE_CLK) disable iff (SRST)
    $rose(st.rst_s2) ##0 st.state == sar_ctrl_pkg::ST_RESET ##1 st.rst_s2[*2]
    |-> ##[1:EXIT_CYC] st.state == sar_ctrl_pkg::ST_ACQUIRE || !st.rst_s2)
    else $error("reset exit delay not kept");

  a_conv_start: assert property ( // RULE10
    @(posedge CORE_CLK) disable iff (SRST)
    st.state == sar_ctrl_pkg::ST_ACQUIRE && st.cnv_s2 && !st.cnv_d && st.rst_s2
    |=> st.state == sar_ctrl_pkg::ST_CONVERT && !st.active && st.timer == 16'(`CONV_CYCLES))
    else $error("start edge did not begin a conversion");

  a_conv_hold: assert property ( // RULE11
    @(posedge CORE_CLK) disable iff (SRST)
    st.state == sar_ctrl_pkg::ST_CONVERT && st.timer > 16'h0001 && st.rst_s2
    |=> st.state == sar_ctrl_pkg::ST_CONVERT)
    else $error("conversion left early");

  a_conv_bound: assert property ( // RULE8
    @(posedge CORE_CLK) disable iff (SRST)
    $rose(st.state == sar_ctrl_pkg::ST_CONVERT) |-> ##[1:CONV_CYC] st.state != sar_ctrl_pkg::ST_CONVERT)
    else $error("conversion ran too long");

  a_result_code: assert property ( // RULE1
    @(posedge CORE_CLK) disable iff (SRST)
    $rose(st.active) && $past(st.state) == sar_ctrl_pkg::ST_CONVERT && $past(st.rst_s2)
    |-> RESULT == sat_code($past(ANALOG_CODE)))
    else $error("result coding wrong");

  a_result_stable: assert property ( // RULE25
    @(posedge CORE_CLK) disable iff (SRST)
    st.state != sar_ctrl_pkg::ST_CONVERT |=> $stable(RESULT) || $rose(st.active))
    else $error("result changed outside conversion end");

  a_ready_follow: assert property ( // RULE7
    @(posedge CORE_CLK) disable iff (SRST)
    st.state == sar_ctrl_pkg::ST_CONVERT && st.cs_s2 |-> !READY_INDICATOR && !st.active)
    else $error("ready high during conversion");

  a_short_nop: assert property ( // RULE23
    @(posedge CORE_CLK) disable iff (SRST)
    st.cs_s2 && !st.cs_d && link.cnt < `CMD_MIN_CLOCKS && st.phase == sar_ctrl_pkg::CMD_IDLE
    |=> st.phase == sar_ctrl_pkg::CMD_IDLE ##1 !st.wr_en)
    else $error("short frame produced a command");

  a_read_word: assert property ( // RULE24
    @(posedge CORE_CLK) disable iff (SRST)
    !st.cs_s2 && st.cs_d && st.rd_pending |=> st.output_shift_register == {$past(st.rd_data), 14'h0000})
    else $error("read word layout wrong");

  a_ready_cmd_busy: assert property ( // RULE7
    @(posedge CORE_CLK) disable iff (SRST)
    st.cs_s2 && !st.cs_d && link.cnt >= `CMD_MIN_CLOCKS && st.phase == sar_ctrl_pkg::CMD_IDLE
    && st.state != sar_ctrl_pkg::ST_RESET |-> !READY_INDICATOR ##1 !READY_INDICATOR ##1 !READY_INDICATOR)
    else $error("ready rose before the command finished");

  a_oe_in_frame: assert property ( // RULE4
    @(posedge CORE_CLK) disable iff (SRST)
    st.state != sar_ctrl_pkg::ST_RESET && !st.cs_s2 |-> SDO_OE)
    else $error("serial output not driven inside a frame");

  a_launch_serial: assert property ( // RULE22
    @(posedge CORE_CLK) disable iff (SRST)
    !st.cs_s2 && !st.cs_d && !launch_sel && !st.sclk_s2 && st.sclk_d
    |=> st.output_shift_register == {$past(st.output_shift_register[20:0]), 1'b0})
    else $error("serial clock launch did not shift");

  a_launch_internal: assert property ( // RULE22
    @(posedge CORE_CLK) disable iff (SRST)
    !st.cs_s2 && !st.cs_d && launch_sel && st.div == `INT_LAUNCH_DIV - 8'h01
    |=> st.output_shift_register == {$past(st.output_shift_register[20:0]), 1'b0} && st.div == 8'h00)
    else $error("internal clock launch did not shift");

  a_write_apply: assert property ( // RULE18
    @(posedge CORE_CLK) disable iff (SRST)
    st.phase == sar_ctrl_pkg::CMD_APPLY && opcode == `OPC_WR && st.state != sar_ctrl_pkg::ST_RESET
    |=> st.wr_en && st.wr_data == $past(mask) && st.wr_addr == $past(st.cmd[`ADDR_MSB:`ADDR_LSB]))
    else $error("write command did not write the data field");

  a_set_apply: assert property ( // RULE17
    @(posedge CORE_CLK) disable iff (SRST)
    st.phase == sar_ctrl_pkg::CMD_APPLY && opcode == `OPC_SET && st.state != sar_ctrl_pkg::ST_RESET
    |=> st.wr_en && st.wr_data == ($past(mem_rd) | $past(mask)))
    else $error("set command wrote a wrong value");

  a_clear_apply: assert property ( // RULE16
    @(posedge CORE_CLK) disable iff (SRST)
    st.phase == sar_ctrl_pkg::CMD_APPLY && opcode == `OPC_CLR && st.state != sar_ctrl_pkg::ST_RESET
    |=> st.wr_en && st.wr_data == ($past(mem_rd) & ~$past(mask)))
    else $error("clear command wrote a wrong value");

  a_nop_apply: assert property ( // RULE20
    @(posedge CORE_CLK) disable iff (SRST)
    st.phase == sar_ctrl_pkg::CMD_APPLY && opcode != `OPC_CLR && opcode != `OPC_SET
    && opcode != `OPC_WR && opcode != `OPC_RD |=> !st.wr_en)
    else $error("no-operation command wrote a register");

endmodule : sar_ctrl

// file: rtl/sar_ctrl_consts.svh
`ifndef SAR_CTRL_CONSTS_SVH
`define SAR_CTRL_CONSTS_SVH

// Core clock, the on-chip conversion clock
`define CORE_PERIOD_NS    10
// Conversion length
`define CONV_TIME_NS      600
`define CONV_CYCLES       ((`CONV_TIME_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
// Delay from reset release to the acquire state
`define RST_EXIT_NS       200
`define RST_EXIT_CYCLES   ((`RST_EXIT_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
// Least low width of the reset pin the host must give
`define RST_LOW_NS        100
`define RST_LOW_CYCLES    ((`RST_LOW_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)

// Command word layout
`define WORD_BITS         22
`define OPC_MSB           21
`define OPC_LSB           17
`define ADDR_MSB          16
`define ADDR_LSB          8
`define DATA_MSB          7
`define CMD_MIN_CLOCKS    5'h16

// Opcodes
`define OPC_CLR           5'h10
`define OPC_RD            5'h11
`define OPC_WR            5'h12
`define OPC_SET           5'h13

// Configuration registers
`define NUM_CFG_REGS      9
`define CFG_LAST_ADDR     9'h008
`define CFG_RESET_VAL     8'h00
`define CFG_LAUNCH_ADDR   4'h0
`define CFG_LAUNCH_BIT    0
`define INT_LAUNCH_DIV    8'h04

// Result coding limits
`define CODE_NEG_FS       18'h20000
`define CODE_POS_FS       18'h1FFFF
`define CODE_MIN_IN       20'shE0000
`define CODE_MAX_IN       20'sh1FFFF

`endif

// file: rtl/sar_ctrl_pkg.sv
`include "sar_ctrl_consts.svh"

package sar_ctrl_pkg;

  typedef enum logic [1:0] {ST_RESET, ST_ACQUIRE, ST_CONVERT} state_e;

  typedef enum logic [1:0] {CMD_IDLE, CMD_FETCH, CMD_APPLY} cmd_e;

  typedef struct packed {
    state_e      state;
    cmd_e        phase;
    logic        rst_s1;
    logic        rst_s2;
    logic        cnv_s1;
    logic        cnv_s2;
    logic        cnv_d;
    logic        cs_s1;
    logic        cs_s2;
    logic        cs_d;
    logic        sclk_s1;
    logic        sclk_s2;
    logic        sclk_d;
    logic        link_clr;
    logic [15:0] timer;
    logic        active;
    logic [17:0] result;
    logic [21:0] output_shift_register;
    logic        sdo_oe;
    logic [7:0]  div;
    logic        rd_pending;
    logic [7:0]  rd_data;
    logic [21:0] cmd;
    logic        wr_en;
    logic [8:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        ready;
  } core_s;

  typedef struct packed {
    logic [21:0] input_shift_register;
    logic [4:0]  cnt;
  } link_s;

  typedef struct packed {
    logic [`NUM_CFG_REGS-1:0][7:0] regs;
    logic [7:0]                    rd_data;
  } cfg_s;

endpackage : sar_ctrl_pkg

// file: verif/host_link_model.sv
module host_link_model (
  output logic            SCLK,
  output logic            CS_N,
  output logic            SDI,
  input  wire logic       SDO,
  input  wire logic       SDO_OE,
  input  wire logic       READY
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    SDI = 1'b0;
  end

  // Link clock runs only inside a frame; output bits are taken at the falling edge, before the device shifts
  task automatic frame(input logic [21:0] cmd, input int nclk, output logic [21:0] got, output logic ok);
    int n;
    got = '0;
    CS_N = 1'b0;
    #100;
    for (int i = nclk - 1; i >= 0; i--) begin
      SDI = (i < 22) ? cmd[i] : ~SDI;
      #32;
      SCLK = 1'b1;
      #32;
      got = {got[20:0], SDO_OE ? SDO : 1'bx};
      SCLK = 1'b0;
    end
    #32;
    // A released data line must not keep looking like the last bit
    SDI = ~SDI;
    CS_N = 1'b1;
    #70;
    n = 0;
    while (READY !== 1'b1 && n < 200) begin
      #10;
      n++;
    end
    ok = (READY === 1'b1);
  endtask : frame
endmodule : host_link_model

// file: verif/tb_top.sv
`include "sar_ctrl_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic [19:0] code;
    logic [17:0] exp;
  } row_s;

  logic        core_clk;
  logic        srst;
  logic        rst_n;
  logic        conv_start;
  logic        cs_n;
  logic        sclk;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic        ready;
  logic [19:0] analog_code;
  logic [17:0] result;
  logic [21:0] got;
  int          fails = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          n;
  row_s        rows [9];
  logic [21:0] noops [5] = '{22'h000000, 22'h3FFFFF, {5'h14, 9'h003, 8'hFF}, {5'h01, 9'h003, 8'hFF},
                             {5'h1E, 9'h003, 8'h00}};

  sar_ctrl dut (
    .CORE_CLK         (core_clk),
    .SRST             (srst),
    .RST_N            (rst_n),
    .CONVERSION_START (conv_start),
    .CS_N             (cs_n),
    .SCLK             (sclk),
    .SDI              (sdi),
    .ANALOG_CODE      (analog_code),
    .SDO              (sdo),
    .SDO_OE           (sdo_oe),
    .READY_INDICATOR  (ready),
    .RESULT           (result)
  );

  host_link_model host (
    .SCLK   (sclk),
    .CS_N   (cs_n),
    .SDI    (sdi),
    .SDO    (sdo),
    .SDO_OE (sdo_oe),
    .READY  (ready)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic summarize();
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [21:0] seen, input logic [21:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_ready(input logic lvl, output int cnt);
    cnt = 0;
    while (ready !== lvl && cnt < 400) begin
      @(posedge core_clk);
      #1;
      cnt++;
    end
  endtask : wait_ready

  task automatic convert(input logic [19:0] code, output int total);
    int k;
    @(posedge core_clk);
    #1;
    analog_code = code;
    conv_start = 1'b1;
    wait_ready(1'b0, total);
    conv_start = 1'b0;
    wait_ready(1'b1, k);
    total = total + k;
  endtask : convert

  task automatic xfer(input logic [21:0] cmd, input int nclk, output logic [21:0] word);
    logic ok;
    host.frame(cmd, nclk, word, ok);
    check("ready_after_frame", ok, 1'b1);
  endtask : xfer

  task automatic rd(input logic [8:0] addr, input logic [7:0] exp);
    xfer({5'h11, addr, 8'h00}, 22, got);
    xfer(22'h000000, 22, got);
    check("reg_read", got, {exp, 14'h0000});
  endtask : rd

  initial begin
    srst = 1'b1;
    rst_n = 1'b1;
    conv_start = 1'b0;
    analog_code = '0;
    rows = '{'{20'hCF2C0, 18'h20000}, '{20'hE0000, 18'h20000}, '{20'hE0001, 18'h20001},
             '{20'hFFFFF, 18'h3FFFF}, '{20'h00000, 18'h00000}, '{20'h00001, 18'h00001},
             '{20'h1FFFF, 18'h1FFFF}, '{20'h20000, 18'h1FFFF}, '{20'h30D40, 18'h1FFFF}};
    repeat (10) @(posedge core_clk);
    #1;
    check("ready_in_reset", ready, 1'b0);
    check("oe_in_reset", sdo_oe, 1'b0);
    check("result_in_reset", result, 18'h00000);
    srst = 1'b0;
    wait_ready(1'b1, n);
    check("ready_after_reset", n < 40, 1'b1);
    foreach (rows[i]) begin
      convert(rows[i].code, n);
      check("conv_time", n >= `CONV_CYCLES && n <= `CONV_CYCLES + 4, 1'b1);
      check("result", result, rows[i].exp);
      xfer(22'h000000, 22, got);
      check("frame_word", got, {rows[i].exp, 4'h0});
    end
    // Start pin wiggles during a conversion must not launch another one
    convert(20'h00005, n);
    @(posedge core_clk);
    #1;
    conv_start = 1'b1;
    wait_ready(1'b0, n);
    repeat (15) @(posedge core_clk);
    #1;
    conv_start = 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    conv_start = 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    conv_start = 1'b0;
    wait_ready(1'b1, n);
    check("wiggle_conv_time", n + 28 >= `CONV_CYCLES && n + 28 <= `CONV_CYCLES + 4, 1'b1);
    check("held_result", result, 18'h00005);
    wait_ready(1'b0, n);
    check("no_extra_conv", n, 400);
    xfer({5'h12, 9'h003, 8'hA5}, 22, got);
    rd(9'h003, 8'hA5);
    xfer({5'h13, 9'h003, 8'h0F}, 22, got);
    rd(9'h003, 8'hAF);
    xfer({5'h10, 9'h003, 8'h81}, 22, got);
    rd(9'h003, 8'h2E);
    foreach (noops[i]) xfer(noops[i], 22, got);
    rd(9'h003, 8'h2E);
    xfer({5'h12, 9'h003, 8'h55}, 21, got);
    rd(9'h003, 8'h2E);
    xfer({5'h12, 9'h003, 8'h55}, 25, got);
    rd(9'h003, 8'h55);
    xfer({5'h12, 9'h008, 8'hC3}, 22, got);
    rd(9'h008, 8'hC3);
    xfer({5'h12, 9'h009, 8'hC3}, 22, got);
    rd(9'h009, 8'h00);
    // Two frames on the internal launch clock, the idle one and the clearing one; their shift pace is watched inside the design
    xfer({5'h13, 9'h000, 8'h01}, 22, got);
    xfer(22'h000000, 22, got);
    xfer({5'h10, 9'h000, 8'h01}, 22, got);
    rd(9'h000, 8'h00);
    @(posedge core_clk);
    #1;
    rst_n = 1'b0;
    wait_ready(1'b0, n);
    check("rst_entry", n <= 5, 1'b1);
    repeat (`RST_LOW_CYCLES) @(posedge core_clk);
    #1;
    check("oe_in_rst", sdo_oe, 1'b0);
    rst_n = 1'b1;
    wait_ready(1'b1, n);
    check("rst_exit", n >= `RST_EXIT_CYCLES && n <= `RST_EXIT_CYCLES + 6, 1'b1);
    rd(9'h003, 8'h00);
    rd(9'h008, 8'h00);
    summarize();
  end
endmodule : tb_top
